// ===== hw/dio_pkg.sv
// constants, register map and field layout of the eight-channel digital i/o port
// Operation
// - eight channels form one byte, channel n at bit n, for input and output.
// - config reset: all inputs, outputs one, no invert/latch, pull-ups, masked, push-pull.
// - input read of an output channel returns the terminal level, not the register.
// - single-channel input read reads the whole input register, releasing all latches.
// - latched change then revert: first read shows change, next read shows original.
// - output write to an input channel loads the register without driving the terminal.
// - output read returns the output register, not the terminal level.
// - port-wide output write updates all eight output bits at once.
// - port-wide input read samples all eight inputs at one instant.
// - each channel reports interrupt status one while interrupting, zero otherwise.
// - non-latched change interrupts unless masked; read or revert clears it.
// - latched change interrupts and captures level; revert neither clears nor alters.
// - mask bit zero enables the channel interrupt, one suppresses it.
// - direction bit zero selects output, one selects input.
package dio_pkg;
   localparam int          DIO_CHANNELS     = 8;
   localparam int          DIO_ADDR_WIDTH   = 8;
   // register byte addresses
   localparam logic [7:0]  DIO_INPUT_ADDR   = 8'h00;
   localparam logic [7:0]  DIO_OUTPUT_ADDR  = 8'h04;
   localparam logic [7:0]  DIO_DIR_ADDR     = 8'h08;
   localparam logic [7:0]  DIO_PULLSEL_ADDR = 8'h0C;
   localparam logic [7:0]  DIO_PULLEN_ADDR  = 8'h10;
   localparam logic [7:0]  DIO_INVERT_ADDR  = 8'h14;
   localparam logic [7:0]  DIO_LATCH_ADDR   = 8'h18;
   localparam logic [7:0]  DIO_MASK_ADDR    = 8'h1C;
   localparam logic [7:0]  DIO_OTYPE_ADDR   = 8'h20;
   localparam logic [7:0]  DIO_STATUS_ADDR  = 8'h24;
   localparam logic [7:0]  DIO_CTRL_ADDR    = 8'h28;
   localparam logic [7:0]  DIO_BITIN_ADDR   = 8'h2C;
   localparam logic [7:0]  DIO_BITOUT_ADDR  = 8'h30;
   // field positions
   localparam int          DIO_CTRL_RESET_BIT = 0;
   localparam int          DIO_OTYPE_BIT      = 0;
   localparam int          DIO_BIT_CHAN_LSB   = 0;
   localparam int          DIO_BIT_VAL_BIT    = 8;
   // configuration reset values
   localparam logic [7:0]  DIO_OUTPUT_RESET  = 8'hFF;
   localparam logic [7:0]  DIO_DIR_RESET     = 8'hFF;
   localparam logic [7:0]  DIO_PULLSEL_RESET = 8'hFF;
   localparam logic [7:0]  DIO_PULLEN_RESET  = 8'hFF;
   localparam logic [7:0]  DIO_INVERT_RESET  = 8'h00;
   localparam logic [7:0]  DIO_LATCH_RESET   = 8'h00;
   localparam logic [7:0]  DIO_MASK_RESET    = 8'hFF;
   localparam logic        DIO_OTYPE_RESET   = 1'b0;
   localparam logic [31:0] DIO_ZERO_WORD     = 32'h00000000;
endpackage : dio_pkg

// ===== hw/dio_sync.sv
// two-flop synchroniser for the terminal levels
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : dio_sync
`default_nettype wire

// ===== hw/dio_port.sv
// eight-channel digital i/o port with latching, interrupt status and apb registers
`timescale 1ns/1ps
`default_nettype none
module dio_port #(
   parameter int CHANNELS = 8
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [dio_pkg::DIO_ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]                    pwdata,
   output var  logic [31:0]                    prdata,
   output var  logic                           pready,
   output var  logic                           pslverr,
   input  wire logic [7:0]                     term_in,
   output var  logic [7:0]                     term_out,
   output var  logic [7:0]                     term_oe_n,
   output var  logic [7:0]                     pull_en,
   output var  logic [7:0]                     pull_up,
   output var  logic                           irq_n
);
   import dio_pkg::*;

   // the register layout is fixed at one byte of channels
   if (CHANNELS != DIO_CHANNELS) begin : g_bad_channels
      $error("dio_port supports exactly eight channels");
   end

   // registers that software writes
   logic [7:0] output_levels_reg;
   logic [7:0] dir_reg;
   logic [7:0] pullsel_reg;
   logic [7:0] pullen_reg;
   logic [7:0] invert_reg;
   logic [7:0] latch_reg;
   logic [7:0] mask_reg;
   logic       otype_reg;
   // per-channel input tracking
   logic [7:0] input_levels_reg;   // latched capture per channel
   logic [7:0] ref_reg;            // value returned by last input read
   logic [7:0] status_reg;
   // terminal view and bus decode
   logic [7:0] pin_sync;
   logic [7:0] level_now;
   logic [7:0] input_view;
   logic       access;
   logic       wr_en;
   logic       rd_en;
   logic       cfg_reset;
   logic       input_read;
   logic       addr_ok;
   logic [2:0] bit_chan;
   logic [31:0] rdata_next;

   // pins are asynchronous to pclk
   dio_sync #(
      .WIDTH (8)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (term_in),
      .sync_out (pin_sync)
   );

   // apb handshake: single-cycle access phase
   assign access   = psel && penable;
   assign wr_en    = access && pwrite;
   assign rd_en    = access && !pwrite;
   assign bit_chan = pwdata[DIO_BIT_CHAN_LSB +: 3];
   assign cfg_reset = wr_en && (paddr == DIO_CTRL_ADDR) && pwdata[DIO_CTRL_RESET_BIT];
   // any input read releases all channels
   assign input_read = rd_en && ((paddr == DIO_INPUT_ADDR) || (paddr == DIO_BITIN_ADDR));

   // terminal level after optional inversion
   assign level_now = pin_sync ^ invert_reg;

   // address decode for defined offsets
   always_comb begin
      unique case (paddr)
         DIO_INPUT_ADDR, DIO_OUTPUT_ADDR, DIO_DIR_ADDR, DIO_PULLSEL_ADDR,
         DIO_PULLEN_ADDR, DIO_INVERT_ADDR, DIO_LATCH_ADDR, DIO_MASK_ADDR,
         DIO_OTYPE_ADDR, DIO_STATUS_ADDR, DIO_CTRL_ADDR, DIO_BITIN_ADDR,
         DIO_BITOUT_ADDR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // read mux; bit reads take the channel from pwdata is not possible, so
   // single-channel input reads return the whole byte and software picks a bit
   always_comb begin
      rdata_next = DIO_ZERO_WORD;
      unique case (paddr)
         DIO_INPUT_ADDR:   rdata_next[7:0] = input_view;
         // bit read still reads whole register
         DIO_BITIN_ADDR:   rdata_next[7:0] = input_view;
         DIO_OUTPUT_ADDR:  rdata_next[7:0] = output_levels_reg;
         DIO_BITOUT_ADDR:  rdata_next[7:0] = output_levels_reg;
         DIO_DIR_ADDR:     rdata_next[7:0] = dir_reg;
         DIO_PULLSEL_ADDR: rdata_next[7:0] = pullsel_reg;
         DIO_PULLEN_ADDR:  rdata_next[7:0] = pullen_reg;
         DIO_INVERT_ADDR:  rdata_next[7:0] = invert_reg;
         DIO_LATCH_ADDR:   rdata_next[7:0] = latch_reg;
         DIO_MASK_ADDR:    rdata_next[7:0] = mask_reg;
         DIO_OTYPE_ADDR:   rdata_next[DIO_OTYPE_BIT] = otype_reg;
         DIO_STATUS_ADDR:  rdata_next[7:0] = status_reg;
         default:          rdata_next = DIO_ZERO_WORD;
      endcase
   end

   // pready is high in the access cycle only: the answer never waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // an unmapped address is refused beside pready; decode drops its write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   // read data taken at the setup edge stand until the next read, so an input
   // read can compare what it returned with the level at its access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= DIO_ZERO_WORD;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata_next;
      end
   end

   // direction, one bit per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_reg <= DIO_DIR_RESET;
      end else if (cfg_reset) begin
         dir_reg <= DIO_DIR_RESET;
      end else if (wr_en && (paddr == DIO_DIR_ADDR)) begin
         dir_reg <= pwdata[7:0];
      end
   end

   // pull direction select, one means up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullsel_reg <= DIO_PULLSEL_RESET;
      end else if (cfg_reset) begin
         pullsel_reg <= DIO_PULLSEL_RESET;
      end else if (wr_en && (paddr == DIO_PULLSEL_ADDR)) begin
         pullsel_reg <= pwdata[7:0];
      end
   end

   // pull enable per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullen_reg <= DIO_PULLEN_RESET;
      end else if (cfg_reset) begin
         pullen_reg <= DIO_PULLEN_RESET;
      end else if (wr_en && (paddr == DIO_PULLEN_ADDR)) begin
         pullen_reg <= pwdata[7:0];
      end
   end

   // input inversion per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         invert_reg <= DIO_INVERT_RESET;
      end else if (cfg_reset) begin
         invert_reg <= DIO_INVERT_RESET;
      end else if (wr_en && (paddr == DIO_INVERT_ADDR)) begin
         invert_reg <= pwdata[7:0];
      end
   end

   // input latching per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= DIO_LATCH_RESET;
      end else if (cfg_reset) begin
         latch_reg <= DIO_LATCH_RESET;
      end else if (wr_en && (paddr == DIO_LATCH_ADDR)) begin
         latch_reg <= pwdata[7:0];
      end
   end

   // interrupt mask per channel, one suppresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= DIO_MASK_RESET;
      end else if (cfg_reset) begin
         mask_reg <= DIO_MASK_RESET;
      end else if (wr_en && (paddr == DIO_MASK_ADDR)) begin
         mask_reg <= pwdata[7:0];
      end
   end

   // output type, shared by all channels; one is open-drain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         otype_reg <= DIO_OTYPE_RESET;
      end else if (cfg_reset) begin
         otype_reg <= DIO_OTYPE_RESET;
      end else if (wr_en && (paddr == DIO_OTYPE_ADDR)) begin
         otype_reg <= pwdata[DIO_OTYPE_BIT];
      end
   end

   // output register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_levels_reg <= DIO_OUTPUT_RESET;
      end else if (cfg_reset) begin
         output_levels_reg <= DIO_OUTPUT_RESET;
      end else if (wr_en && (paddr == DIO_OUTPUT_ADDR)) begin
         // all eight bits in one write
         output_levels_reg <= pwdata[7:0];
      end else if (wr_en && (paddr == DIO_BITOUT_ADDR)) begin
         output_levels_reg[bit_chan] <= pwdata[DIO_BIT_VAL_BIT];
      end
   end

   // per-channel view, change detection, latch capture, status and pin drive
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_chan
         logic changed;
         assign changed = level_now[g] != ref_reg[g];

         // latched channels show the capture while their status is set, others the terminal
         assign input_view[g] = (latch_reg[g] && status_reg[g]) ? input_levels_reg[g]
                                                                : level_now[g];

         // reference is the value software was last shown, so no edge is lost
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ref_reg[g] <= 1'b0;
            end else if (cfg_reset) begin
               ref_reg[g] <= level_now[g];
            end else if (input_read) begin
               // a reverted latched input interrupts again
               ref_reg[g] <= prdata[g];
            end
         end

         // captured level, frozen while a latched channel is pending
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               input_levels_reg[g] <= 1'b0;
            end else if (cfg_reset || input_read || !latch_reg[g]) begin
               input_levels_reg[g] <= level_now[g];
            end else if (!status_reg[g] && changed && !mask_reg[g]) begin
               // capture on change, hold through revert
               input_levels_reg[g] <= level_now[g];
            end
         end

         // interrupt status per channel
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               status_reg[g] <= 1'b0;
            end else if (cfg_reset) begin
               status_reg[g] <= 1'b0;
            end else if (input_read) begin
               // read clears; a level moved since the returned value wins
               status_reg[g] <= !mask_reg[g] && (level_now[g] != prdata[g]);
            end else if (latch_reg[g]) begin
               // set on change, held through a revert
               if (!status_reg[g] && changed && !mask_reg[g]) begin
                  status_reg[g] <= 1'b1;
               end
            end else begin
               status_reg[g] <= changed && !mask_reg[g];
            end
         end

         // direction zero drives; inputs stay undriven
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               term_out[g]  <= DIO_OUTPUT_RESET[g];
               term_oe_n[g] <= 1'b1;
            end else if (otype_reg) begin
               // open-drain drives only a zero; a one releases the pin
               term_out[g]  <= 1'b0;
               term_oe_n[g] <= dir_reg[g] | output_levels_reg[g];
            end else begin
               term_out[g]  <= output_levels_reg[g];
               term_oe_n[g] <= dir_reg[g];
            end
         end

         // open-drain outputs lose their internal pull, so resistors sit outside
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pull_en[g] <= DIO_PULLEN_RESET[g];
               pull_up[g] <= DIO_PULLSEL_RESET[g];
            end else begin
               pull_en[g] <= pullen_reg[g] && !(otype_reg && !dir_reg[g]);
               pull_up[g] <= pullsel_reg[g];
            end
         end
      end
   endgenerate

   // shared request while any status set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= !(|status_reg);
      end
   end
endmodule : dio_port
`default_nettype wire

// ===== testbench/dio_port_props.sv
// concurrent checks on the dio port apb handshake and terminal controls
`timescale 1ns/1ps
`default_nettype none
module dio_port_props
   import dio_pkg::*;
(
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [DIO_ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic [7:0]                term_out,
   input wire logic [7:0]                term_oe_n,
   input wire logic [7:0]                pull_up
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a completed write, the only thing allowed to move the pins
   logic wr;
   assign wr = psel && penable && pwrite && pready;
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && pready; endsequence
   ready_after_setup_a: assert property (setup_s |=> access_s)
      else $error("no ready in the access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("read data above bit 7");
   unmapped_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("error answer not clean");
   cfg_reset_a: assert property (wr && paddr == DIO_CTRL_ADDR && pwdata[0]
      |-> ##[1:2] (term_oe_n == 8'hFF && pull_up == 8'hFF))
      else $error("config reset left pins set");
   out_cause_a: assert property ($changed(term_out) |-> $past(wr) || $past(wr, 2))
      else $error("drive value moved without a write");
   dir_cause_a: assert property ($changed(term_oe_n) |-> $past(wr) || $past(wr, 2))
      else $error("direction moved without a write");
endmodule : dio_port_props
`default_nettype wire

// ===== testbench/dio_term_model.sv
// terminal model: resolves each pin from the port drive, an outside source and the pulls
`timescale 1ns/1ps
`default_nettype none
module dio_term_model (
   input wire logic [7:0] term_out,
   input wire logic [7:0] term_oe_n,
   input wire logic [7:0] pull_en,
   input wire logic [7:0] pull_up,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output var logic [7:0] level
);
   // pin shows drive
   // a floating pin shows the inverse of the outside value, never a kind guess
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!term_oe_n[i]) level[i] = term_out[i];
         else if (ext_en[i]) level[i] = ext_val[i];
         else if (pull_en[i]) level[i] = pull_up[i];
         else level[i] = ~ext_val[i];
      end
   end
endmodule : dio_term_model
`default_nettype wire

// ===== testbench/dio_port_tb_top.sv
// self-checking bench for the eight-channel dio port
`timescale 1ns/1ps
`default_nettype none
module dio_port_tb_top;
   import dio_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  ext_val = 8'h00;
   logic [7:0]  ext_en = 8'h00;
   logic [31:0] prdata, r;
   logic        pready, pslverr, irq_n, last_err;
   logic [7:0]  term_in, term_out, term_oe_n, pull_en, pull_up;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #12.5 pclk = ~pclk;
   dio_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .term_in, .term_out, .term_oe_n, .pull_en, .pull_up, .irq_n);
   dio_term_model i_term (.term_out, .term_oe_n, .pull_en, .pull_up, .ext_val, .ext_en,
      .level(term_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; pready is sampled at the edge, then the request is dropped
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask : rd
   task automatic settle;
      repeat (5) @(posedge pclk);
   endtask : settle
   task automatic s_reset;
      logic [7:0] ra [8];
      logic [7:0] rv [8];
      ra = '{DIO_OUTPUT_ADDR, DIO_DIR_ADDR, DIO_PULLSEL_ADDR, DIO_PULLEN_ADDR,
             DIO_INVERT_ADDR, DIO_LATCH_ADDR, DIO_MASK_ADDR, DIO_OTYPE_ADDR};
      rv = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00};
      // move every item off its default so the config reset has work to do
      for (int i = 0; i < 8; i++) apb(1'b1, ra[i], {24'h0, ~rv[i]});
      apb(1'b1, DIO_CTRL_ADDR, 32'h1);
      settle();
      for (int i = 0; i < 8; i++) rd(ra[i], {24'h0, rv[i]});
      chk({pull_en, pull_up}, 16'hFFFF);
      apb(1'b0, 8'h3C, 32'h0);
      chk({last_err, r}, {1'b1, 32'h0});
   endtask : s_reset
   // outputs loaded while inputs, then driven once turned round
   task automatic s_out;
      apb(1'b1, DIO_OUTPUT_ADDR, 32'hA5);
      settle();
      chk(term_oe_n, 8'hFF);
      rd(DIO_OUTPUT_ADDR, 32'hA5);
      apb(1'b1, DIO_DIR_ADDR, 32'h0);
      settle();
      chk({term_oe_n, term_out}, 16'h00A5);
      rd(DIO_INPUT_ADDR, 32'hA5);
      // open-drain: ones release the pin, pulls drop on outputs
      apb(1'b1, DIO_OTYPE_ADDR, 32'h1);
      settle();
      chk({term_oe_n, term_out, pull_en}, 24'hA50000);
      rd(DIO_INPUT_ADDR, 32'hA5);
      apb(1'b1, DIO_OTYPE_ADDR, 32'h0);
      apb(1'b1, DIO_BITOUT_ADDR, 32'h7);
      rd(DIO_OUTPUT_ADDR, 32'h25);
      apb(1'b1, DIO_DIR_ADDR, 32'hFF);
   endtask : s_out
   task automatic s_irq;
      ext_en <= 8'hFF;
      settle();
      rd(DIO_INPUT_ADDR, 32'h0);
      apb(1'b1, DIO_MASK_ADDR, 32'h0);
      settle();
      rd(DIO_STATUS_ADDR, 32'h0);
      ext_val <= 8'h04;
      settle();
      rd(DIO_STATUS_ADDR, 32'h04);
      chk(irq_n, 1'b0);
      rd(DIO_INPUT_ADDR, 32'h04);
      settle();
      rd(DIO_STATUS_ADDR, 32'h0);
      chk(irq_n, 1'b1);
      ext_val <= 8'h0C;
      settle();
      rd(DIO_STATUS_ADDR, 32'h08);
      ext_val <= 8'h04;
      settle();
      rd(DIO_STATUS_ADDR, 32'h0);
      apb(1'b1, DIO_MASK_ADDR, 32'h10);
      ext_val <= 8'h14;
      settle();
      rd(DIO_STATUS_ADDR, 32'h0);
   endtask : s_irq
   task automatic s_latch;
      ext_val <= 8'h00;
      settle();
      rd(DIO_INPUT_ADDR, 32'h0);
      apb(1'b1, DIO_LATCH_ADDR, 32'hFF);
      apb(1'b1, DIO_MASK_ADDR, 32'h0);
      ext_val <= 8'h02;
      settle();
      ext_val <= 8'h00;
      settle();
      rd(DIO_STATUS_ADDR, 32'h02);
      rd(DIO_INPUT_ADDR, 32'h02);
      settle();
      rd(DIO_INPUT_ADDR, 32'h0);
      ext_val <= 8'h60;
      settle();
      rd(DIO_STATUS_ADDR, 32'h60);
      apb(1'b0, DIO_BITIN_ADDR, 32'h5);
      chk(r, 32'h60);
      settle();
      rd(DIO_STATUS_ADDR, 32'h0);
   endtask : s_latch
   task automatic results;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_out();
      s_irq();
      s_latch();
      results();
   end
endmodule : dio_port_tb_top
bind dio_port dio_port_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .term_out, .term_oe_n, .pull_up);
`default_nettype wire
